/* File: verilog/aps_params.svh */
`ifndef APS_PARAMS_SVH
`define APS_PARAMS_SVH

// register offsets on the serial control port
`define APS_CHAN_STATUS_OFS     8'h70
`define APS_GLOBAL_ONE_OFS      8'h71
`define APS_GLOBAL_TWO_OFS      8'h72

// reset values
`define APS_STATUS_RESET        8'h00

// channel status bit positions
`define APS_LEFT_DC_BIT         3
`define APS_RIGHT_DC_BIT        2
`define APS_LEFT_OC_BIT         1
`define APS_RIGHT_OC_BIT        0

// first global status bit positions
`define APS_OTP_CRC_BIT         7
`define APS_COEFF_WR_BIT        6
`define APS_BOOT_LOAD_BIT       5
`define APS_CLOCK_BIT           2
`define APS_OVERVOLT_BIT        1
`define APS_UNDERVOLT_BIT       0

// clear control: bit of the error clear register
`define APS_CLEAR_BIT           7

// mask control bit positions
`define APS_OVERCURRENT_REPORT_MASK_BIT         0
`define APS_DC_ERROR_REPORT_MASK_BIT         1
`define APS_MASK_UV_BIT         2
`define APS_MASK_CLK_BIT        4

`endif

/* File: verilog/aps_pkg.sv */
package aps_pkg;

    // one register byte
    typedef logic [7:0] aps_byte_t;

    // raw error events from the protection sensors and the two digital checks
    typedef struct packed {
        logic left_dc;
        logic right_dc;
        logic left_oc;
        logic right_oc;
        logic clock;
        logic overvolt;
        logic undervolt;
        logic otp_crc;
        logic coeff_wr;
    } aps_events_t;

    // sticky flag group
    typedef struct packed {
        logic left_dc_error_flag;
        logic right_dc_error_flag;
        logic left_overcurrent_flag;
        logic right_overcurrent_flag;
        logic clock_error_flag;
        logic supply_overvoltage_flag;
        logic supply_undervoltage_flag;
        logic otp_crc_flag;
        logic filter_coeff_write_flag;
    } aps_flags_t;

endpackage : aps_pkg

/* File: verilog/aps_flag_if.sv */
interface aps_flag_if;
    import aps_pkg::*;

    aps_flags_t flags;      // sticky error flags
    logic       boot_fail;  // boot load outcome level

    modport producer (
        output flags,
        output boot_fail
    );
    modport consumer (
        input flags,
        input boot_fail
    );
endinterface : aps_flag_if

/* File: verilog/aps_sync.sv */
module aps_sync (
    input  wire logic core_clk_in,
    input  wire logic rst_n_in,
    input  wire logic async_in,
    output logic      sync_out
);
    logic meta_q;   // first stage, read only by the second
    logic sync_q;   // second stage

    // two flops against metastability on pin inputs
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule : aps_sync

/* File: verilog/aps_flag_bank.sv */
`include "aps_params.svh"

module aps_flag_bank (
    input  wire logic           core_clk_in,
    input  wire logic           rst_n_in,
    input  aps_pkg::aps_events_t events_in,
    input  wire logic           clear_in,
    input  wire logic           boot_done_in,
    input  wire logic           boot_fail_in,
    aps_flag_if.producer        flag_if
);
    import aps_pkg::*;

    aps_flags_t flags_q;    // sticky flags
    logic       boot_q;     // boot load result

    // flags latch on events and hold until clear; set wins over clear
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            flags_q <= '0;
        end else begin
            flags_q.left_dc_error_flag       <= events_in.left_dc   | (flags_q.left_dc_error_flag & ~clear_in);
            flags_q.right_dc_error_flag      <= events_in.right_dc  | (flags_q.right_dc_error_flag & ~clear_in);
            flags_q.left_overcurrent_flag    <= events_in.left_oc   | (flags_q.left_overcurrent_flag & ~clear_in);
            flags_q.right_overcurrent_flag   <= events_in.right_oc  | (flags_q.right_overcurrent_flag & ~clear_in);
            flags_q.clock_error_flag         <= events_in.clock     | (flags_q.clock_error_flag & ~clear_in);
            flags_q.supply_overvoltage_flag  <= events_in.overvolt  | (flags_q.supply_overvoltage_flag & ~clear_in);
            flags_q.supply_undervoltage_flag <= events_in.undervolt | (flags_q.supply_undervoltage_flag & ~clear_in);
            flags_q.otp_crc_flag             <= events_in.otp_crc   | (flags_q.otp_crc_flag & ~clear_in);
            flags_q.filter_coeff_write_flag  <= events_in.coeff_wr  | (flags_q.filter_coeff_write_flag & ~clear_in);
        end
    end

    // boot result follows each completed load, not the clear
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            boot_q <= 1'b0;
        end else if (boot_done_in) begin
            boot_q <= boot_fail_in;
        end
    end

    assign flag_if.flags     = flags_q;
    assign flag_if.boot_fail = boot_q;
endmodule : aps_flag_bank

/* File: verilog/aps_status_regs.sv */
`include "aps_params.svh"

// read-only protection status
// of a two-channel amplifier
// power stage; one clock and
// one asynchronous reset

// Summary of operation
// - left DC error sets channel bit 3
// - right DC error sets channel bit 2
// - left overcurrent sets channel bit 1
// - right overcurrent sets channel bit 0
// - power errors force outputs high impedance
// - power errors drive the error pin
// - flags hold until clear bit 7 written
// - clock error sets global bit 2
// - clock error recovers without software
// - overvoltage sets global bit 1
// - overvoltage recovers when supply returns
// - undervoltage sets global bit 0
// - memory CRC failure sets global bit 7
// - failed coefficient write sets global bit 6
// - global bit 5 shows boot load failure
// - reserved bits read zero
// - channel status read-only at 0x70
// - global status read-only at 0x71, 0x72
// - mask bits suppress error pin reporting
module aps_status_regs (
    input  wire logic              core_clk_in,
    input  wire logic              rst_n_in,
    input  wire logic              left_dc_in,
    input  wire logic              right_dc_in,
    input  wire logic              left_oc_in,
    input  wire logic              right_oc_in,
    input  wire logic              clock_err_in,
    input  wire logic              overvolt_in,
    input  wire logic              undervolt_in,
    input  wire logic              otp_crc_err_in,
    input  wire logic              coeff_wr_err_in,
    input  wire logic              boot_done_in,
    input  wire logic              boot_fail_in,
    input  wire logic              err_clear_wr_in,
    input  aps_pkg::aps_byte_t     err_clear_data_in,
    input  aps_pkg::aps_byte_t     report_mask_in,
    input  wire logic              rd_en_in,
    input  aps_pkg::aps_byte_t     rd_addr_in,
    output aps_pkg::aps_byte_t     rd_data_out,
    output logic                   rd_valid_out,
    output logic                   power_hiz_out,
    output logic                   error_pin_out,
    output logic                   error_pin_oe_out
);
    import aps_pkg::*;

    // data path, in order:
    //   pins -> synchronisers
    //   -> sticky flag bank
    //   -> register images
    //   -> read mux -> read flops

    // protection path:
    //   flags and live levels
    //   -> hi-z and pin flops

    // the host only reads here;
    // no write path exists

    // all outputs come from flops:
    // no glitches reach the pins,
    // at one cycle of latency

    // sensor pin to error pin:
    //   two edges to synchronise,
    //   one edge to latch the flag,
    //   one edge to the pin flop

    // a sensor pulse shorter than
    // a clock may be missed; the
    // comparators hold longer

    // synchronised levels, one
    // per sensor pin
    logic        left_dc_s;      // synchronised sensor levels
    logic        right_dc_s;
    logic        left_oc_s;
    logic        right_oc_s;
    logic        clock_s;
    logic        overvolt_s;
    logic        undervolt_s;
    aps_events_t events;         // grouped events for the flag bank
    logic        clear_pulse;    // software clear strobe
    aps_flag_if  flag_if ();     // flags from the bank

    // images, read stage and
    // protection stage follow
    aps_byte_t   chan_status;    // assembled channel register
    aps_byte_t   global_one;     // assembled global register one
    aps_byte_t   rd_data_d;      // read mux result
    aps_byte_t   rd_data_q;      // registered read data
    logic        rd_valid_q;     // read answer strobe
    logic        hiz_q;          // power stage high impedance
    logic        pin_q;          // error pin level
    logic        hiz_d;          // live fault condition
    logic        pin_d;          // unmasked flags present

    // sensor levels come from the analog side, so each passes
    // two flops; one loop keeps the seven paths identical
    logic [6:0] sense_raw;       // pin levels as they arrive
    logic [6:0] sense_s;         // the same levels, synchronised
    assign sense_raw = {left_dc_in, right_dc_in, left_oc_in, right_oc_in,
                        clock_err_in, overvolt_in, undervolt_in};
    // the first flop of each pair
    // is read by the second only
    generate
        for (genvar g = 0; g < 7; g++) begin : g_sync
            aps_sync u_sync (
                .core_clk_in (core_clk_in),
                .rst_n_in    (rst_n_in),
                .async_in    (sense_raw[g]),
                .sync_out    (sense_s[g])
            );
        end
    endgenerate

    // back to named levels
    assign {left_dc_s, right_dc_s, left_oc_s, right_oc_s, clock_s, overvolt_s, undervolt_s} = sense_s;

    // the two digital checks come
    // from logic on this clock, so
    // they skip the synchroniser

    // a struct keeps the bank's
    // port list short and fixed

    // group events; digital checks arrive on this clock already
    always_comb begin
        events.left_dc   = left_dc_s;
        events.right_dc  = right_dc_s;
        events.left_oc   = left_oc_s;
        events.right_oc  = right_oc_s;
        events.clock     = clock_s;
        events.overvolt  = overvolt_s;
        events.undervolt = undervolt_s;
        events.otp_crc   = otp_crc_err_in;
        events.coeff_wr  = coeff_wr_err_in;
    end

    // the clear register lives
    // elsewhere; only its write
    // strobe and data reach here

    // a write with bit 7 low is
    // ignored on purpose
    // the strobe lasts one cycle,
    // so each write clears once

    // only a write with bit 7 set clears the flags
    assign clear_pulse = err_clear_wr_in & err_clear_data_in[`APS_CLEAR_BIT];

    // the bank holds every sticky
    // flag; a new event in the
    // clear cycle wins, so a fault
    // still present is never lost
    // the bank also keeps the
    // boot result, which only a
    // new boot load can change

    aps_flag_bank u_bank (
        .core_clk_in  (core_clk_in),
        .rst_n_in     (rst_n_in),
        .events_in    (events),
        .clear_in     (clear_pulse),
        .boot_done_in (boot_done_in),
        .boot_fail_in (boot_fail_in),
        .flag_if      (flag_if.producer)
    );

    // register images are built
    // from constants, flags and the
    // boot result; they hold no state

    // channel register layout:
    //   bit 3 left dc
    //   bit 2 right dc
    //   bit 1 left overcurrent
    //   bit 0 right overcurrent
    // reserved bits come from the
    // reset constant, so they read
    // zero whatever the flags do

    // channel register; upper nibble stays zero
    always_comb begin
        chan_status = `APS_STATUS_RESET;
        chan_status[`APS_LEFT_DC_BIT]  = flag_if.flags.left_dc_error_flag;
        chan_status[`APS_RIGHT_DC_BIT] = flag_if.flags.right_dc_error_flag;
        chan_status[`APS_LEFT_OC_BIT]  = flag_if.flags.left_overcurrent_flag;
        chan_status[`APS_RIGHT_OC_BIT] = flag_if.flags.right_overcurrent_flag;
    end

    // global register one layout:
    //   bit 7 memory check
    //   bit 6 coefficient write
    //   bit 5 boot load result
    //   bit 2 clock
    //   bit 1 overvoltage
    //   bit 0 undervoltage
    // bits 4 and 3 are reserved
    // and come from the constant

    // the boot bit is a result,
    // not a flag: clear leaves it

    // global register one; bits 4 and 3 stay zero
    always_comb begin
        global_one = `APS_STATUS_RESET;
        global_one[`APS_OTP_CRC_BIT]   = flag_if.flags.otp_crc_flag;
        global_one[`APS_COEFF_WR_BIT]  = flag_if.flags.filter_coeff_write_flag;
        global_one[`APS_BOOT_LOAD_BIT] = flag_if.boot_fail;
        global_one[`APS_CLOCK_BIT]     = flag_if.flags.clock_error_flag;
        global_one[`APS_OVERVOLT_BIT]  = flag_if.flags.supply_overvoltage_flag;
        global_one[`APS_UNDERVOLT_BIT] = flag_if.flags.supply_undervoltage_flag;
    end

    // unmapped offsets read zero
    // rather than x, so a host
    // bug shows as a clean value

    // the second global register
    // is kept as a zero image
    // until its bits are defined
    // the case is unique: the
    // offsets never overlap

    // read decode; register two layout is outside this block, reads zero
    always_comb begin
        unique case (rd_addr_in)
            `APS_CHAN_STATUS_OFS: rd_data_d = chan_status;
            `APS_GLOBAL_ONE_OFS:  rd_data_d = global_one;
            `APS_GLOBAL_TWO_OFS:  rd_data_d = `APS_STATUS_RESET;
            default:              rd_data_d = `APS_STATUS_RESET;
        endcase
    end

    // read data is taken at the
    // request edge, so a flag that
    // sets in that same cycle
    // shows on the next read

    // rd_data_out keeps the last
    // value between reads

    // registered read answer one cycle after the request; no write path exists
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_data_q  <= `APS_STATUS_RESET;
            rd_valid_q <= 1'b0;
        end else begin
            rd_valid_q <= rd_en_in;
            if (rd_en_in) begin
                rd_data_q <= rd_data_d;
            end
        end
    end

    // two sources feed the hi-z:
    //   latched dc and overcurrent
    //   flags, which need a clear
    //   live clock and supply
    //   levels, which recover

    // the power stage may come
    // back while the status bits
    // still show the old fault;
    // software reads and clears

    // a clock fault that clears
    // restarts the stage without
    // any software step

    // the same holds for supply
    // over and undervoltage

    // hi-z follows the live condition, so clock and supply faults recover
    // by themselves; latched DC/OC flags keep the stage off until cleared
    always_comb begin
        hiz_d = flag_if.flags.left_dc_error_flag | flag_if.flags.right_dc_error_flag
              | flag_if.flags.left_overcurrent_flag | flag_if.flags.right_overcurrent_flag
              | clock_s | overvolt_s | undervolt_s;
    end

    // the error pin follows the
    // sticky flags, not the live
    // levels, so the host sees a
    // fault that already passed

    // mask bits only silence the
    // pin; flags and hi-z do not
    // look at the mask

    // the memory, coefficient and
    // boot bits never reach the
    // pin: they are not power
    // stage faults

    // error pin: unmasked sticky flags; overvoltage shares the undervoltage mask
    always_comb begin
        pin_d = ((flag_if.flags.left_dc_error_flag | flag_if.flags.right_dc_error_flag)
                    & ~report_mask_in[`APS_DC_ERROR_REPORT_MASK_BIT])
              | ((flag_if.flags.left_overcurrent_flag | flag_if.flags.right_overcurrent_flag)
                    & ~report_mask_in[`APS_OVERCURRENT_REPORT_MASK_BIT])
              | (flag_if.flags.clock_error_flag & ~report_mask_in[`APS_MASK_CLK_BIT])
              | ((flag_if.flags.supply_undervoltage_flag | flag_if.flags.supply_overvoltage_flag)
                    & ~report_mask_in[`APS_MASK_UV_BIT]);
    end

    // one flop each keeps the
    // pins free of decode glitches
    // both reset low: no fault is
    // shown until one is seen

    // protection outputs registered so the pins come from flops
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            hiz_q <= 1'b0;
            pin_q <= 1'b0;
        end else begin
            hiz_q <= hiz_d;
            pin_q <= pin_d;
        end
    end

    // outputs straight from flops;
    // the pin enable copies the
    // pin so the line is driven
    // only while it is asserted,
    // and left to its pull-up
    // otherwise

    assign rd_data_out      = rd_data_q;
    assign rd_valid_out     = rd_valid_q;
    assign power_hiz_out    = hiz_q;
    assign error_pin_out    = pin_q;
    assign error_pin_oe_out = pin_q;  // open-drain style: drive only when asserting
endmodule : aps_status_regs

/* File: testbench/aps_status_regs_sva.sv */
module aps_status_regs_sva (
    input wire logic               core_clk_in,
    input wire logic               rst_n_in,
    input wire logic               left_dc_in,
    input wire logic               right_oc_in,
    input wire logic               err_clear_wr_in,
    input wire aps_pkg::aps_byte_t err_clear_data_in,
    input wire aps_pkg::aps_byte_t report_mask_in,
    input wire logic               rd_en_in,
    input wire aps_pkg::aps_byte_t rd_addr_in,
    input wire aps_pkg::aps_byte_t rd_data_out,
    input wire logic               rd_valid_out,
    input wire logic               power_hiz_out,
    input wire logic               error_pin_out,
    input wire logic               error_pin_oe_out
);
    timeunit 1ns;
    timeprecision 1ns;
    import aps_pkg::*;
    logic clr_hit; // a clear request with bit 7 set
    assign clr_hit = err_clear_wr_in & err_clear_data_in[7];
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    // a fault level that rises and stays for two more edges, long enough to pass the synchroniser
    sequence s_held(s);
        $rose(s) ##1 s [*2];
    endsequence
    sequence s_read(aps_byte_t a);
        rd_en_in && (rd_addr_in == a);
    endsequence
    property p_valid; rd_en_in |=> rd_valid_out; endproperty
    property p_no_valid; !rd_en_in |=> !rd_valid_out; endproperty
    property p_chan_res; s_read(8'h70) |=> rd_data_out[7:4] == 4'h0; endproperty
    property p_glob_res; s_read(8'h71) |=> rd_data_out[4:3] == 2'h0; endproperty
    property p_two_zero; s_read(8'h72) |=> rd_data_out == 8'h00; endproperty
    property p_hiz; s_held(left_dc_in) |-> ##2 power_hiz_out; endproperty
    property p_pin; s_held(right_oc_in) ##0 (report_mask_in == 8'h00) |-> ##2 error_pin_out; endproperty
    property p_oe; error_pin_oe_out == error_pin_out; endproperty
    // the pin may only fall through a clear or a mask
    property p_sticky;
        error_pin_out && !clr_hit && !$past(clr_hit) |=> (report_mask_in != 8'h00) || error_pin_out;
    endproperty
    a_valid: assert property (p_valid) else $error("read not answered");
    a_no_valid: assert property (p_no_valid) else $error("read answer without request");
    a_chan_res: assert property (p_chan_res) else $error("channel reserved bits set");
    a_glob_res: assert property (p_glob_res) else $error("global reserved bits set");
    a_two_zero: assert property (p_two_zero) else $error("second global register not zero");
    a_hiz: assert property (p_hiz) else $error("outputs not high impedance");
    a_pin: assert property (p_pin) else $error("error pin not raised");
    a_oe: assert property (p_oe) else $error("pin enable differs from pin");
    a_sticky: assert property (p_sticky) else $error("error pin dropped without clear");
endmodule : aps_status_regs_sva

bind aps_status_regs aps_status_regs_sva u_sva (
    .core_clk_in, .rst_n_in, .left_dc_in, .right_oc_in, .err_clear_wr_in, .err_clear_data_in,
    .report_mask_in, .rd_en_in, .rd_addr_in, .rd_data_out, .rd_valid_out, .power_hiz_out,
    .error_pin_out, .error_pin_oe_out
);

/* File: testbench/aps_host_model.sv */
module aps_host_model (
    input  wire logic          core_clk_in,
    output logic               rd_en_out,
    output aps_pkg::aps_byte_t rd_addr_out,
    input  aps_pkg::aps_byte_t rd_data_in,
    input  wire logic          rd_valid_in
);
    timeunit 1ns;
    timeprecision 1ns;
    import aps_pkg::*;
    initial begin
        rd_en_out   = 1'b0;
        rd_addr_out = 8'h00;
    end
    // one byte read: strobe for one edge, then wait a bounded time for the answer
    task automatic read_reg(input aps_byte_t addr, output aps_byte_t data);
        int n;
        @(negedge core_clk_in);
        rd_en_out   = 1'b1;
        rd_addr_out = addr;
        @(negedge core_clk_in);
        rd_en_out   = 1'b0;
        rd_addr_out = ~addr; // idle address moves so a stale decode cannot hide
        n = 0;
        while (rd_valid_in !== 1'b1 && n < 4) begin
            @(negedge core_clk_in);
            n++;
        end
        data = (rd_valid_in === 1'b1) ? rd_data_in : 8'hxx; // no answer reads as unknown
    endtask : read_reg
endmodule : aps_host_model

/* File: testbench/tb.sv */
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import aps_pkg::*;
    logic      core_clk_in, rst_n_in, left_dc_in, right_dc_in, left_oc_in, right_oc_in;
    logic      clock_err_in, overvolt_in, undervolt_in, otp_crc_err_in, coeff_wr_err_in;
    logic      boot_done_in, boot_fail_in, err_clear_wr_in, rd_en_in, rd_valid_out;
    logic      power_hiz_out, error_pin_out, error_pin_oe_out;
    aps_byte_t err_clear_data_in, report_mask_in, rd_addr_in, rd_data_out;
    logic [3:0] chan; // left dc, right dc, left oc, right oc: same order as the status bits
    logic [2:0] glob; // clock, overvoltage, undervoltage
    int         fail_count, checks_done, cycles;
    assign {left_dc_in, right_dc_in, left_oc_in, right_oc_in} = chan;
    assign {clock_err_in, overvolt_in, undervolt_in} = glob;

    aps_status_regs DUT (
        .core_clk_in, .rst_n_in, .left_dc_in, .right_dc_in, .left_oc_in, .right_oc_in, .clock_err_in,
        .overvolt_in, .undervolt_in, .otp_crc_err_in, .coeff_wr_err_in, .boot_done_in, .boot_fail_in,
        .err_clear_wr_in, .err_clear_data_in, .report_mask_in, .rd_en_in, .rd_addr_in, .rd_data_out,
        .rd_valid_out, .power_hiz_out, .error_pin_out, .error_pin_oe_out
    );
    aps_host_model host (
        .core_clk_in, .rd_en_out(rd_en_in), .rd_addr_out(rd_addr_in), .rd_data_in(rd_data_out),
        .rd_valid_in(rd_valid_out)
    );

    initial begin
        core_clk_in = 1'b0;
        forever #10 core_clk_in = ~core_clk_in;
    end
    // hang guard: the whole run needs well under a thousand cycles
    always @(posedge core_clk_in) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            $display("CHECK FAILED at %0t: run timed out", $time);
            results();
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk_in);
    endtask : cyc
    task automatic chk(input aps_byte_t got, input aps_byte_t exp, input string what);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic chk_bit(input logic got, input logic exp, input string what);
        chk({7'h00, got}, {7'h00, exp}, what);
    endtask : chk_bit
    task automatic rd(input aps_byte_t a, input aps_byte_t exp, input string what);
        aps_byte_t d;
        host.read_reg(a, d);
        chk(d, exp, what);
    endtask : rd
    // clear strobe with bit 7 set, then let the pin settle
    task automatic clear;
        @(negedge core_clk_in);
        err_clear_wr_in   = 1'b1;
        err_clear_data_in = 8'h80;
        cyc(1);
        err_clear_wr_in = 1'b0;
        cyc(2);
    endtask : clear

    task automatic t_reset;
        rd(8'h70, 8'h00, "channel reset");
        rd(8'h71, 8'h00, "global reset");
        rd(8'h55, 8'h00, "unmapped read");
        chk_bit(error_pin_out | power_hiz_out, 1'b0, "pins after reset");
        $display("test reset done");
    endtask : t_reset
    task automatic t_channel;
        for (int i = 0; i < 4; i++) begin
            chan = 4'h1 << i;
            cyc(3);
            chan = 4'h0;
            cyc(3);
            rd(8'h70, 8'h01 << i, "channel flag");
            chk_bit(power_hiz_out, 1'b1, "channel hiz");
            chk_bit(error_pin_out, 1'b1, "channel pin");
            cyc(20);
            rd(8'h70, 8'h01 << i, "channel sticky");
            rd(8'h72, 8'h00, "second global");
            clear();
            rd(8'h70, 8'h00, "channel cleared");
            chk_bit(error_pin_out | power_hiz_out, 1'b0, "channel released");
        end
        $display("test channel done");
    endtask : t_channel
    task automatic t_global;
        for (int i = 0; i < 3; i++) begin
            glob = 3'h1 << i;
            cyc(5);
            chk_bit(power_hiz_out, 1'b1, "global hiz");
            chk_bit(error_pin_out, 1'b1, "global pin");
            rd(8'h71, 8'h01 << i, "global flag");
            glob = 3'h0;
            cyc(5);
            chk_bit(power_hiz_out, 1'b0, "global recovery");
            rd(8'h71, 8'h01 << i, "global sticky");
            clear();
            rd(8'h71, 8'h00, "global cleared");
        end
        otp_crc_err_in = 1'b1;
        cyc(1);
        otp_crc_err_in = 1'b0;
        coeff_wr_err_in = 1'b1;
        cyc(1);
        coeff_wr_err_in = 1'b0;
        cyc(2);
        rd(8'h71, 8'hc0, "memory and coefficient flags");
        clear();
        $display("test global done");
    endtask : t_global
    task automatic t_boot;
        boot_fail_in = 1'b1;
        boot_done_in = 1'b1;
        cyc(1);
        {boot_done_in, boot_fail_in} = 2'h0;
        cyc(2);
        rd(8'h71, 8'h20, "boot failed");
        clear();
        rd(8'h71, 8'h20, "boot after clear");
        boot_done_in = 1'b1;
        cyc(1);
        boot_done_in = 1'b0;
        cyc(2);
        rd(8'h71, 8'h00, "boot good");
        $display("test boot done");
    endtask : t_boot
    task automatic t_mask;
        report_mask_in = 8'h17;
        chan = 4'h6; // right dc and left oc
        glob = 3'h7;
        cyc(5);
        chk_bit(power_hiz_out, 1'b1, "masked hiz");
        chk_bit(error_pin_out, 1'b0, "masked pin");
        {chan, glob} = 7'h00;
        report_mask_in = 8'h00;
        cyc(4);
        chk_bit(error_pin_out, 1'b1, "unmasked pin");
        clear();
        chk_bit(error_pin_out, 1'b0, "pin cleared");
        $display("test mask done");
    endtask : t_mask

    task automatic results;
        $display("checks %0d failures %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : results

    initial begin
        {rst_n_in, chan, glob, otp_crc_err_in, coeff_wr_err_in} = 10'h000;
        {boot_done_in, boot_fail_in, err_clear_wr_in} = 3'h0;
        err_clear_data_in = 8'h00;
        report_mask_in = 8'h00;
        {fail_count, checks_done, cycles} = '0;
        cyc(10);
        rst_n_in = 1'b1;
        cyc(1);
        t_reset();
        t_channel();
        t_global();
        t_boot();
        t_mask();
        results();
    end
endmodule : tb
